// ### verilog/uedi_pkg.sv
// package: register map, field layout and constants of the endpoint done-interrupt block
package uedi_pkg;
  localparam int UEDI_NUM_EP = 8;
  localparam int UEDI_ADDR_W = 32;
  // register byte addresses
  localparam logic [31:0] UEDI_ADDR_FLAGS_LO = 32'h64018050;
  localparam logic [31:0] UEDI_ADDR_FLAGS_HI = 32'h64018054;
  localparam logic [31:0] UEDI_ADDR_EN_LO = 32'h64018058;
  localparam logic [31:0] UEDI_ADDR_EN_HI = 32'h6401805C;
  localparam logic [31:0] UEDI_ADDR_CTRL = 32'h64018060;
  // control register fields
  localparam int UEDI_CTRL_CONTROL_BIT_A_BIT = 0;
  // reset values
  localparam logic [7:0] UEDI_FLAGS_RST = 8'h00;
  localparam logic [7:0] UEDI_EN_RST = 8'h00;
  localparam logic [15:0] UEDI_FLAGS16_RST = 16'h0000;
  localparam logic UEDI_CONTROL_BIT_A_RST = 1'b0;
  // tx fifo fill state meaning empty
  localparam logic [1:0] UEDI_FIFO_EMPTY = 2'b00;
  // bit index within a 16-bit vector: odd = receive, even = transmit
  localparam int UEDI_RX_OFS = 1;
  localparam int UEDI_TX_OFS = 0;
endpackage : uedi_pkg

// ### verilog/uedi_apb_slave.sv
// apb slave decode: register selects, write and read strobes
`timescale 1ns/1ns
module uedi_apb_slave
  import uedi_pkg::*;
(
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  output logic pready,
  output logic pslverr,
  output logic wr_flags_lo,
  output logic wr_flags_hi,
  output logic wr_en_lo,
  output logic wr_en_hi,
  output logic wr_ctrl,
  output logic rd_access,
  output logic [2:0] rd_sel
);
  wire logic access = psel & penable;
  wire logic hit_fl = (paddr == UEDI_ADDR_FLAGS_LO);
  wire logic hit_fh = (paddr == UEDI_ADDR_FLAGS_HI);
  wire logic hit_el = (paddr == UEDI_ADDR_EN_LO);
  wire logic hit_eh = (paddr == UEDI_ADDR_EN_HI);
  wire logic hit_ct = (paddr == UEDI_ADDR_CTRL);
  wire logic mapped = hit_fl | hit_fh | hit_el | hit_eh | hit_ct;

  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign wr_flags_lo = access & pwrite & hit_fl;
  assign wr_flags_hi = access & pwrite & hit_fh;
  assign wr_en_lo = access & pwrite & hit_el;
  assign wr_en_hi = access & pwrite & hit_eh;
  assign wr_ctrl = access & pwrite & hit_ct;
  assign rd_access = access & ~pwrite;
  assign rd_sel = hit_fl ? 3'h1 : hit_fh ? 3'h2 : hit_el ? 3'h3 : hit_eh ? 3'h4 :
                  hit_ct ? 3'h5 : 3'h0;
endmodule : uedi_apb_slave

// ### verilog/uedi_done_bit.sv
// one done flag with standard and pended copies
`timescale 1ns/1ns
module uedi_done_bit
  import uedi_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hw_set,
  input wire logic hold,
  input wire logic fw_wr,
  input wire logic fw_val,
  input wire logic control_bit_a,
  input wire logic control_bit_a_release,
  output logic flag
);
  logic std_q;
  logic std_d;
  logic pnd_q;
  logic pnd_d;

  // hardware only ever sets; with control_bit_a set it lands in the hidden copy
  wire logic hw_to_std = (hw_set | hold) & ~control_bit_a;
  wire logic hw_to_pnd = (hw_set | hold) & control_bit_a;

  always_comb begin
    std_d = std_q;
    if (fw_wr) begin
      std_d = fw_val;
    end
    // a hardware set in the release cycle itself would be lost with the hidden copy
    if (control_bit_a_release) begin
      std_d = std_d | pnd_q | hw_to_pnd;
    end
    // a set in the same cycle as a clear wins
    if (hw_to_std) begin
      std_d = 1'b1;
    end
    pnd_d = control_bit_a_release ? 1'b0 : (pnd_q | hw_to_pnd);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      std_q <= 1'b0;
      pnd_q <= 1'b0;
    end else begin
      std_q <= std_d;
      pnd_q <= pnd_d;
    end
  end

  assign flag = std_q;
endmodule : uedi_done_bit

// ### verilog/uedi_top.sv
// endpoint done-interrupt flags, enables and request for eight usb endpoints
//
// Contract
// - enable register 0: odd bits enable receive-done, even bits transmit-done, eps 0-3
// - enable register 1: same layout for endpoints 4 to 7
// - enabled and set done flag raises the interrupt request
// - disabled source never interrupts; its flag still updates and reads back
// - all enable bits are read/write and reset to zero
// - flag registers: eps 0-3 and 4-7, odd receive, even transmit
// - no done flag is ever set by hardware for an isochronous endpoint
// - flag 1 means pending, 0 none, regardless of enable
// - hardware events only set flags; hardware never clears one
// - firmware writing one sets a flag, interrupting like a hardware set
// - receive-done set on good acknowledged receive data or receive error
// - transmit-done set on acknowledged transmit or transmit error
// - nak-on-empty with empty fifo on in: nak, set transmit-done and void
// - such transmit-done holds until void flag or nak enable cleared
// - control_bit_a set: hardware updates hidden copy, firmware only the standard copy
// - control_bit_a cleared: flag becomes standard copy or pended copy
`timescale 1ns/1ns
module uedi_top
  import uedi_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] ep_isochronous,
  input wire logic [7:0] rx_good_pulse,
  input wire logic [7:0] rx_error_pulse,
  input wire logic [7:0] tx_ack_pulse,
  input wire logic [7:0] tx_error_pulse,
  input wire logic [7:0] in_token_pulse,
  input wire logic [7:0] nak_on_empty_enable,
  input wire logic [15:0] tx_fifo_fill_state,
  input wire logic [7:0] tx_void_flag,
  output logic [7:0] nak_send_pulse,
  output logic [7:0] tx_void_set_pulse,
  output logic irq
);
  // ==========================================================
  // bus decode
  logic wr_flags_lo;
  logic wr_flags_hi;
  logic wr_en_lo;
  logic wr_en_hi;
  logic wr_ctrl;
  logic rd_access;
  logic [2:0] rd_sel;

  uedi_apb_slave u_apb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pready(pready),
    .pslverr(pslverr),
    .wr_flags_lo(wr_flags_lo),
    .wr_flags_hi(wr_flags_hi),
    .wr_en_lo(wr_en_lo),
    .wr_en_hi(wr_en_hi),
    .wr_ctrl(wr_ctrl),
    .rd_access(rd_access),
    .rd_sel(rd_sel)
  );

  // ==========================================================
  // enables and control_bit_a control
  logic [7:0] en_lo_q;
  logic [7:0] en_hi_q;
  logic control_bit_a_q;
  wire logic control_bit_a_d = wr_ctrl ? pwdata[UEDI_CTRL_CONTROL_BIT_A_BIT] : control_bit_a_q;
  // release on the firmware write that clears control_bit_a
  wire logic control_bit_a_release = control_bit_a_q & ~control_bit_a_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_lo_q <= UEDI_EN_RST;
      en_hi_q <= UEDI_EN_RST;
      control_bit_a_q <= UEDI_CONTROL_BIT_A_RST;
    end else begin
      if (wr_en_lo) begin
        en_lo_q <= pwdata[7:0];
      end
      if (wr_en_hi) begin
        en_hi_q <= pwdata[7:0];
      end
      control_bit_a_q <= control_bit_a_d;
    end
  end

  wire logic [15:0] en_all = {en_hi_q, en_lo_q};
  wire logic [15:0] fw_wdata = {pwdata[7:0], pwdata[7:0]};
  wire logic [15:0] fw_wr = {{8{wr_flags_hi}}, {8{wr_flags_lo}}};

  // ==========================================================
  // transaction events per endpoint
  logic [7:0] nak_evt_q;
  logic [7:0] nak_hold_q;
  logic [7:0] nak_evt;
  logic [15:0] hw_set;
  logic [15:0] hold;
  logic [15:0] flags;

  genvar ep;
  generate
    for (ep = 0; ep < UEDI_NUM_EP; ep++) begin : g_ep
      wire logic fifo_empty = (tx_fifo_fill_state[2*ep+1:2*ep] == UEDI_FIFO_EMPTY);
      // isochronous endpoints never report done
      wire logic ok = ~ep_isochronous[ep];
      assign nak_evt[ep] = ok & nak_on_empty_enable[ep] & in_token_pulse[ep] & fifo_empty;
      assign hw_set[2*ep+UEDI_RX_OFS] = ok & (rx_good_pulse[ep] | rx_error_pulse[ep]);
      assign hw_set[2*ep+UEDI_TX_OFS] = ok & (tx_ack_pulse[ep] | tx_error_pulse[ep]
                                              | nak_evt[ep]);
      assign hold[2*ep+UEDI_RX_OFS] = 1'b0;
      // keeps re-asserting the flag while void and nak enable both stand
      assign hold[2*ep+UEDI_TX_OFS] = ok & nak_hold_q[ep] & tx_void_flag[ep]
                                      & nak_on_empty_enable[ep];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nak_evt_q <= UEDI_FLAGS_RST;
      nak_hold_q <= UEDI_FLAGS_RST;
    end else begin
      nak_evt_q <= nak_evt;
      // hold ends when firmware drops void or nak enable
      // void only shows two edges after the event; our own set pulse bridges the gap
      nak_hold_q <= (nak_hold_q | nak_evt) & (tx_void_flag | nak_evt | nak_evt_q)
                    & nak_on_empty_enable;
    end
  end

  assign nak_send_pulse = nak_evt_q;
  assign tx_void_set_pulse = nak_evt_q;

  // ==========================================================
  // done flags
  genvar b;
  generate
    for (b = 0; b < 2 * UEDI_NUM_EP; b++) begin : g_bit
      uedi_done_bit u_bit (
        .pclk(pclk),
        .presetn(presetn),
        .hw_set(hw_set[b]),
        .hold(hold[b]),
        .fw_wr(fw_wr[b]),
        .fw_val(fw_wdata[b]),
        .control_bit_a(control_bit_a_q),
        .control_bit_a_release(control_bit_a_release),
        .flag(flags[b])
      );
    end
  endgenerate

  // ==========================================================
  // interrupt request
  logic irq_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flags & en_all);
    end
  end
  assign irq = irq_q;

  // ==========================================================
  // read data, combinational mux driven only during a read access
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    case (rd_sel)
      3'h1: rd_mux = {24'h000000, flags[7:0]};
      3'h2: rd_mux = {24'h000000, flags[15:8]};
      3'h3: rd_mux = {24'h000000, en_lo_q};
      3'h4: rd_mux = {24'h000000, en_hi_q};
      3'h5: rd_mux = {31'h00000000, control_bit_a_q};
      default: rd_mux = 32'h00000000;
    endcase
  end
  assign prdata = rd_access ? rd_mux : 32'h00000000;
endmodule : uedi_top

// ### verification/uedi_usb_model.sv
// model of the usb transaction engine and fifo status beside the done-interrupt block
`timescale 1ns/1ns
module uedi_usb_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] tx_void_set_pulse,
  output logic [7:0] rx_good_pulse,
  output logic [7:0] rx_error_pulse,
  output logic [7:0] tx_ack_pulse,
  output logic [7:0] tx_error_pulse,
  output logic [7:0] in_token_pulse,
  output logic [7:0] tx_void_flag
);
  // ==========================================================
  // events: kind 4 rx good, 3 rx error, 2 tx ack, 1 tx error, 0 in token
  logic [4:0][7:0] ev = '0;
  logic clr = 1'b0;
  assign {rx_good_pulse, rx_error_pulse, tx_ack_pulse, tx_error_pulse, in_token_pulse} = ev;
  task automatic fire(input int k, input int e);
    @(posedge pclk);
    ev[k] <= 8'h01 << e;
    @(posedge pclk);
    ev[k] <= 8'h00;
  endtask : fire
  task automatic drop_void;
    @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
  endtask : drop_void
  // void stays up until firmware drops it, like the real fifo logic
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_void_flag <= 8'h00;
    else if (clr) tx_void_flag <= 8'h00;
    else tx_void_flag <= tx_void_flag | tx_void_set_pulse;
  end
endmodule : uedi_usb_model

// ### verification/uedi_top_monitor.sv
// checker: apb answer, nak response and irq causes of the done-interrupt block
`timescale 1ns/1ns
module uedi_top_monitor
  import uedi_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] ep_isochronous,
  input wire logic [7:0] rx_good_pulse,
  input wire logic [7:0] rx_error_pulse,
  input wire logic [7:0] tx_ack_pulse,
  input wire logic [7:0] tx_error_pulse,
  input wire logic [7:0] in_token_pulse,
  input wire logic [7:0] nak_on_empty_enable,
  input wire logic [15:0] tx_fifo_fill_state,
  input wire logic [7:0] nak_send_pulse,
  input wire logic [7:0] tx_void_set_pulse,
  input wire logic irq
);
  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite && pready;
  wire logic evt = |{rx_good_pulse, rx_error_pulse, tx_ack_pulse, tx_error_pulse, in_token_pulse};
  // offsets from the first register; only five words are mapped
  wire logic [31:0] ofs = paddr - UEDI_ADDR_FLAGS_LO;
  wire logic hit = ofs inside {32'h0, 32'h4, 32'h8, 32'hC, 32'h10};
  // in token on a non-isochronous endpoint with nak enabled and an empty fifo
  logic [7:0] nak_cond;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      nak_cond[i] = in_token_pulse[i] && nak_on_empty_enable[i] && !ep_isochronous[i]
                    && tx_fifo_fill_state[2*i +: 2] == UEDI_FIFO_EMPTY;
    end
  end
  sequence s_nak_req;
    nak_cond != 8'h00;
  endsequence
  a_ready_high: assert property (pready) else $error("pready low");
  a_slverr_decode: assert property (pslverr == (acc && !hit)) else $error("bad pslverr");
  a_rdata_idle: assert property (!(acc && !pwrite) |-> prdata == 32'h0) else $error("prdata idle");
  a_rdata_upper: assert property (prdata[31:8] == 24'h0) else $error("prdata upper set");
  a_nak_answer: assert property (s_nak_req |=> nak_send_pulse == $past(nak_cond))
    else $error("no nak");
  a_nak_void_pair: assert property (tx_void_set_pulse != 8'h00
    |-> tx_void_set_pulse == $past(nak_cond)) else $error("void");
  a_nak_cause: assert property (nak_send_pulse != 8'h00
    |-> nak_send_pulse == $past(nak_cond)) else $error("nak");
  a_irq_rise: assert property ($rose(irq) |-> $past(wr || evt, 2)) else $error("irq rise");
  a_irq_fall: assert property ($fell(irq) |-> $past(wr, 2)) else $error("irq fall");
endmodule : uedi_top_monitor
bind uedi_top uedi_top_monitor i_uedi_top_monitor (.*);

// ### verification/tb_top.sv
// self-checking bench for the endpoint done-interrupt block
`timescale 1ns/1ns
module tb_top;
  import uedi_pkg::*;
  // ==========================================================
  // signals, instances and bus tasks
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slv;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, irq;
  logic [7:0] ep_isochronous = 8'h00, nak_on_empty_enable = 8'h00, nak_send_pulse;
  logic [7:0] rx_good_pulse, rx_error_pulse, tx_ack_pulse, tx_error_pulse, in_token_pulse;
  logic [7:0] tx_void_flag, tx_void_set_pulse;
  logic [15:0] tx_fifo_fill_state = 16'hFFFF;
  logic [15:0] en16 = 16'h5AA5;
  logic [31:0] ra [4] = '{UEDI_ADDR_FLAGS_LO, UEDI_ADDR_FLAGS_HI, UEDI_ADDR_EN_LO, UEDI_ADDR_EN_HI};
  int n_errors = 0, checks_done = 0;
  uedi_top i_uedi_top (.*);
  uedi_usb_model i_uedi_usb_model (.*);
  always #10 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      close_out();
    end
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] e); apb(1'b0, a, 32'h0); chk(rdv, e); endtask : rd
  task automatic cyc(input int k); repeat (k) @(posedge pclk); endtask : cyc
  // ==========================================================
  // main sequence
  initial begin
    cyc(16);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) rd(ra[i], 32'h0);
    rd(32'h64018064, 32'h0);
    chk({31'h0, slv}, 32'h1);
    wr(ra[2], 32'hFFFFFFA5);
    wr(ra[3], 32'h0000005A);
    rd(ra[2], 32'hA5);
    rd(ra[3], 32'h5A);
    // every rx and tx pulse source of every endpoint, enabled or not
    for (int e = 0; e < 8; e++) begin
      for (int k = 1; k < 5; k++) begin
        i_uedi_usb_model.fire(k, e);
        rd(ra[e / 4], 32'h1 << (2 * (e % 4) + (k > 2)));
        chk({31'h0, irq}, {31'h0, en16[2 * e + (k > 2)]});
        wr(ra[e / 4], 32'h0);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
      end
    end
    wr(ra[1], 32'h40);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    wr(ra[1], 32'h0);
    ep_isochronous <= 8'h04;
    i_uedi_usb_model.fire(4, 2);
    rd(ra[0], 32'h0);
    ep_isochronous <= 8'h00;
    wr(UEDI_ADDR_CTRL, 32'h1);
    i_uedi_usb_model.fire(4, 0);
    rd(ra[0], 32'h0);
    wr(ra[0], 32'h10);
    rd(ra[0], 32'h10);
    wr(UEDI_ADDR_CTRL, 32'h0);
    rd(ra[0], 32'h12);
    wr(ra[0], 32'h0);
    nak_on_empty_enable <= 8'h02;
    tx_fifo_fill_state <= 16'hFFF3;
    i_uedi_usb_model.fire(0, 1);
    // both answer pulses stand for the one cycle after the in token
    @(negedge pclk);
    chk({16'h0, nak_send_pulse, tx_void_set_pulse}, 32'h0202);
    cyc(2);
    chk({24'h0, tx_void_flag}, 32'h02);
    rd(ra[0], 32'h04);
    wr(ra[0], 32'h0);
    rd(ra[0], 32'h04);
    i_uedi_usb_model.drop_void();
    cyc(2);
    wr(ra[0], 32'h0);
    rd(ra[0], 32'h0);
    close_out();
  end
endmodule : tb_top
